// >>> rtl/spi_fifo_controller.sv
// Byte-wide serial peripheral controller with four-entry transmit and receive FIFOs, master or slave.
// Assumes single-cycle register strobes on clk, and a slave clock that only toggles inside frames.
`timescale 1ns/1ps
`include "spi_fifo_controller_defines.svh"
`default_nettype none

// Overview of operation
// - Mode 00: interrupts after one byte.
// - Mode 01: interrupts after two bytes.
// - Mode 10: interrupts after three bytes.
// - Mode 11: four bytes, receive FIFO full.
// - Transmit flush held while bit 13 set.
// - Flushing sends last byte or zero.
// - Transmit writes dropped while flushing.
// - Receive flush held while bit 12 set.
// - Receive flush drops data, no interrupts.
// - Receive read starts transfer in read mode.
// - Continuous master runs until transmit empty.
// - Chip select held low through continuous run.
// - Non-continuous transfers are single bytes.
// - One serial clock stall between write-mode single bytes.
// - Bit 10 loops master data out to in.
// - Receive register read-only at 0a04.
// - Transmit register write-only at 0a08.
// - Baud register sets master clock rate.
// - Bit 6 picks trigger and interrupt source.
// - Bit 7 picks zero or last byte.
// - Bit 1 selects master or slave.
// - Bits 3 and 2 set master polarity, phase.
module spi_fifo_controller (
	input wire logic clk, // system clock
	input wire logic sys_rst, // asynchronous reset, active high
	input wire logic [31:0] regAddr, // register byte address
	input wire logic regWr, // register write strobe
	input wire logic regRd, // register read strobe
	input wire logic [15:0] regWdata, // register write data
	output logic [15:0] regRdata, // register read data, one cycle after the strobe
	input wire logic sclkIn, // serial clock from an external master
	input wire logic csIn_n, // chip select from an external master
	input wire logic mosiIn, // data from an external master
	output logic misoOut, // data to an external master
	input wire logic misoIn, // data from an external slave
	output logic sclkOut, // serial clock in master role
	output logic csOut_n, // chip select in master role
	output logic mosiOut, // data to an external slave
	output logic txIrq, // transmit interrupt level
	output logic rxIrq // receive interrupt level
);

	spi_fifo_pkg::core_s q;
	spi_fifo_pkg::core_s n;
	spi_fifo_pkg::slave_s slv;
	spi_fifo_pkg::slave_s slvN;
	logic misoOut_r;
	logic misoOut_nxt;

	logic txFlush;
	logic rxFlush;
	logic txAvail;
	logic [7:0] nextByte;
	logic rxBit;
	logic [2:0] thresh;
	logic slvEvent;
	logic byteDone;
	logic [7:0] rxByteM;
	logic loadReq;
	logic txPush;
	logic txPop;
	logic rxPush;
	logic rxPop;
	logic [7:0] rxPushData;

	assign txFlush = q.ctrl[`SPI_BIT_TX_FLUSH];
	assign rxFlush = q.ctrl[`SPI_BIT_RX_FLUSH];
	assign txAvail = !txFlush && (q.txCnt != 3'h0);
	assign nextByte = txAvail ? q.txMem[q.txRd] : (q.ctrl[`SPI_BIT_ZERO_FILL] ? `SPI_ZERO_BYTE : q.lastTx);
	assign rxBit = q.ctrl[`SPI_BIT_LOOPBACK] ? q.mosi : q.misoS2;
	assign thresh = {1'b0, q.ctrl[`SPI_BIT_MODE_HI:`SPI_BIT_MODE_LO]} + 3'h1;
	assign slvEvent = q.togS2 ^ q.togS3;

	always_comb
	begin
		n = q;
		byteDone = 1'b0;
		loadReq = 1'b0;
		txPush = 1'b0;
		txPop = 1'b0;
		rxPush = 1'b0;
		rxPop = 1'b0;
		rxByteM = q.rxShift;
		rxPushData = slv.rxByte;

		n.misoS1 = misoIn;
		n.misoS2 = q.misoS1;
		n.togS1 = slv.tog;
		n.togS2 = q.togS1;
		n.togS3 = q.togS2;

		if (regWr)
		begin
			if (regAddr == `SPI_ADDR_CONTROL)
				n.ctrl = regWdata;
			if (regAddr == `SPI_ADDR_BAUD)
				n.baud = regWdata[7:0];
			if (regAddr == `SPI_ADDR_TRANSMIT && !txFlush && q.txCnt != `SPI_FIFO_DEPTH)
				txPush = 1'b1;
		end

		if (regRd)
		begin
			case (regAddr)
				`SPI_ADDR_STATUS: n.rdData = {7'h00, (q.state != spi_fifo_pkg::M_IDLE), q.rxIrq, q.txIrq, q.rxCnt, q.txCnt};
				`SPI_ADDR_RECEIVE:
				begin
					n.rdData = {8'h00, q.rxMem[q.rxRd]};
					rxPop = (q.rxCnt != 3'h0) && !rxFlush;
					if (!q.ctrl[`SPI_BIT_TRIGGER])
						n.startPend = 1'b1;
				end
				`SPI_ADDR_BAUD: n.rdData = {8'h00, q.baud};
				`SPI_ADDR_CONTROL: n.rdData = q.ctrl;
				default: n.rdData = 16'h0000;
			endcase
		end

		// master sequencer, started only in master role
		case (q.state)
			spi_fifo_pkg::M_IDLE:
			begin
				n.sclk = q.ctrl[`SPI_BIT_POLARITY];
				n.cs_n = 1'b1;
				if (q.ctrl[`SPI_BIT_ENABLE] && q.ctrl[`SPI_BIT_MASTER] &&
					(q.ctrl[`SPI_BIT_TRIGGER] ? txAvail : q.startPend))
					loadReq = 1'b1;
			end
			spi_fifo_pkg::M_RUN:
			begin
				if (q.divCnt != 8'h00)
					n.divCnt = q.divCnt - 8'h01;
				else
				begin
					n.divCnt = q.baud;
					n.sclk = ~q.sclk;
					if (!q.half)
					begin
						n.half = 1'b1;
						if (q.ctrl[`SPI_BIT_PHASE])
							n.mosi = q.txShift[7];
						else
							n.rxShift = {q.rxShift[6:0], rxBit};
					end
					else
					begin
						n.half = 1'b0;
						if (q.ctrl[`SPI_BIT_PHASE])
							n.rxShift = {q.rxShift[6:0], rxBit};
						if (q.bitCnt == `SPI_LAST_BIT)
						begin
							byteDone = 1'b1;
							rxByteM = q.ctrl[`SPI_BIT_PHASE] ? {q.rxShift[6:0], rxBit} : q.rxShift;
							if (q.ctrl[`SPI_BIT_CONTINUOUS] && txAvail)
								loadReq = 1'b1;
							else if (!q.ctrl[`SPI_BIT_CONTINUOUS] && q.ctrl[`SPI_BIT_TRIGGER] && txAvail)
							begin
								n.cs_n = 1'b1;
								n.state = spi_fifo_pkg::M_STALL;
							end
							else
							begin
								n.cs_n = 1'b1;
								n.state = spi_fifo_pkg::M_IDLE;
							end
						end
						else
						begin
							n.bitCnt = q.bitCnt + 3'h1;
							n.txShift = {q.txShift[6:0], 1'b0};
							if (!q.ctrl[`SPI_BIT_PHASE])
								n.mosi = q.txShift[6];
						end
					end
				end
			end
			spi_fifo_pkg::M_STALL:
			begin
				if (q.divCnt != 8'h00)
					n.divCnt = q.divCnt - 8'h01;
				else
				begin
					n.divCnt = q.baud;
					n.half = ~q.half;
					if (q.half)
						n.state = spi_fifo_pkg::M_IDLE;
				end
			end
			default: n.state = spi_fifo_pkg::M_IDLE;
		endcase

		if (loadReq)
		begin
			n.txShift = nextByte;
			n.lastTx = nextByte;
			txPop = txAvail;
			if (!q.ctrl[`SPI_BIT_PHASE])
				n.mosi = nextByte[7];
			n.bitCnt = 3'h0;
			n.half = 1'b0;
			n.divCnt = q.baud;
			n.cs_n = 1'b0;
			// A receive read in the load cycle asks for the next transfer, so it is kept.
			n.startPend = regRd && (regAddr == `SPI_ADDR_RECEIVE) && !q.ctrl[`SPI_BIT_TRIGGER];
			n.state = spi_fifo_pkg::M_RUN;
		end

		// Slave transmit byte is handed over only between bytes, so the link side sees it stable.
		if (!q.ctrl[`SPI_BIT_MASTER] && q.ctrl[`SPI_BIT_ENABLE])
		begin
			if (slvEvent)
				n.slvTxValid = 1'b0;
			else if (!q.slvTxValid)
			begin
				n.slvTx = nextByte;
				n.lastTx = nextByte;
				n.slvTxValid = 1'b1;
				txPop = txAvail;
			end
		end

		if (byteDone || (slvEvent && !q.ctrl[`SPI_BIT_MASTER]))
		begin
			if (byteDone)
				rxPushData = rxByteM;
			if (!rxFlush && (q.rxCnt != `SPI_FIFO_DEPTH || rxPop))
				rxPush = 1'b1;
			if (q.sentCnt + 3'h1 >= thresh)
			begin
				n.sentCnt = 3'h0;
				n.txPend = 1'b1;
			end
			else
				n.sentCnt = q.sentCnt + 3'h1;
		end
		else if (regWr && regAddr == `SPI_ADDR_TRANSMIT)
			n.txPend = 1'b0;

		if (txFlush)
		begin
			n.txRd = q.txWr;
			n.txCnt = 3'h0;
		end
		else
		begin
			if (txPush)
			begin
				n.txMem[q.txWr] = regWdata[7:0];
				n.txWr = q.txWr + 2'h1;
			end
			if (txPop)
				n.txRd = q.txRd + 2'h1;
			n.txCnt = q.txCnt + {2'b00, txPush} - {2'b00, txPop};
		end

		if (rxFlush)
		begin
			n.rxRd = q.rxWr;
			n.rxCnt = 3'h0;
		end
		else
		begin
			if (rxPush)
			begin
				n.rxMem[q.rxWr] = rxPushData;
				n.rxWr = q.rxWr + 2'h1;
			end
			if (rxPop)
				n.rxRd = q.rxRd + 2'h1;
			n.rxCnt = q.rxCnt + {2'b00, rxPush} - {2'b00, rxPop};
		end

		n.txIrq = n.txPend && q.ctrl[`SPI_BIT_TRIGGER] && !n.ctrl[`SPI_BIT_RX_FLUSH];
		n.rxIrq = (n.rxCnt >= thresh) && !q.ctrl[`SPI_BIT_TRIGGER] && !n.ctrl[`SPI_BIT_RX_FLUSH];
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			q <= '0;
			q.ctrl <= `SPI_CONTROL_RESET;
			q.baud <= `SPI_BAUD_RESET;
			q.cs_n <= 1'b1;
			q.state <= spi_fifo_pkg::M_IDLE;
		end
		else
			q <= n;
	end

	// Link side: bits are sampled on the rising serial edge while selected.
	always_comb
	begin
		slvN = slv;
		if (!csIn_n)
		begin
			if (slv.bitCnt == 3'h0)
				slvN.txHold = q.slvTx;
			slvN.shift = {slv.shift[6:0], mosiIn};
			if (slv.bitCnt == `SPI_LAST_BIT)
			begin
				slvN.rxByte = {slv.shift[6:0], mosiIn};
				slvN.tog = ~slv.tog;
			end
			slvN.bitCnt = slv.bitCnt + 3'h1;
		end
	end

	always_ff @(posedge sclkIn or posedge sys_rst)
	begin
		if (sys_rst)
			slv <= '0;
		else
			slv <= slvN;
	end

	// The outgoing bit changes on the falling edge, so the first bit waits for the first falling edge.
	assign misoOut_nxt = (slv.bitCnt == 3'h0) ? q.slvTx[7] : slv.txHold[~slv.bitCnt];

	always_ff @(negedge sclkIn or posedge sys_rst)
	begin
		if (sys_rst)
			misoOut_r <= 1'b0;
		else
			misoOut_r <= misoOut_nxt;
	end

	assign regRdata = q.rdData;
	assign sclkOut = q.sclk;
	assign csOut_n = q.cs_n;
	assign mosiOut = q.mosi;
	assign misoOut = misoOut_r;
	assign txIrq = q.txIrq;
	assign rxIrq = q.rxIrq;

endmodule : spi_fifo_controller

`default_nettype wire

// >>> shared/spi_fifo_controller_defines.svh
// Register offsets, control bit positions, reset values and FIFO sizing for the serial controller.
// Assumes the including file wants plain text macros; no logic lives here.
`ifndef SPI_FIFO_CONTROLLER_DEFINES_SVH
`define SPI_FIFO_CONTROLLER_DEFINES_SVH

`define SPI_ADDR_STATUS 32'hffff0a00
`define SPI_ADDR_RECEIVE 32'hffff0a04
`define SPI_ADDR_TRANSMIT 32'hffff0a08
`define SPI_ADDR_BAUD 32'hffff0a0c
`define SPI_ADDR_CONTROL 32'hffff0a10

`define SPI_CONTROL_RESET 16'h0000
`define SPI_BAUD_RESET 8'h00
`define SPI_RECEIVE_RESET 8'h00

`define SPI_BIT_ENABLE 0
`define SPI_BIT_MASTER 1
`define SPI_BIT_PHASE 2
`define SPI_BIT_POLARITY 3
`define SPI_BIT_TRIGGER 6
`define SPI_BIT_ZERO_FILL 7
`define SPI_BIT_LOOPBACK 10
`define SPI_BIT_CONTINUOUS 11
`define SPI_BIT_RX_FLUSH 12
`define SPI_BIT_TX_FLUSH 13
`define SPI_BIT_MODE_LO 14
`define SPI_BIT_MODE_HI 15

`define SPI_FIFO_DEPTH 3'h4
`define SPI_ZERO_BYTE 8'h00
`define SPI_LAST_BIT 3'h7

`endif

// >>> shared/spi_fifo_pkg.sv
// Types shared by the serial controller: master sequencer states and the state records of both clock domains.
// Assumes the defines header is on the include path.
`include "spi_fifo_controller_defines.svh"

package spi_fifo_pkg;

	typedef enum logic [1:0] {M_IDLE, M_RUN, M_STALL} master_state_e;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [7:0] baud;
		logic [3:0][7:0] txMem;
		logic [1:0] txWr;
		logic [1:0] txRd;
		logic [2:0] txCnt;
		logic [3:0][7:0] rxMem;
		logic [1:0] rxWr;
		logic [1:0] rxRd;
		logic [2:0] rxCnt;
		logic [15:0] rdData;
		master_state_e state;
		logic [7:0] divCnt;
		logic [2:0] bitCnt;
		logic half;
		logic [7:0] txShift;
		logic [7:0] rxShift;
		logic [7:0] lastTx;
		logic sclk;
		logic cs_n;
		logic mosi;
		logic [2:0] sentCnt;
		logic txPend;
		logic txIrq;
		logic rxIrq;
		logic startPend;
		logic misoS1;
		logic misoS2;
		logic togS1;
		logic togS2;
		logic togS3;
		logic [7:0] slvTx;
		logic slvTxValid;
	} core_s;

	typedef struct packed {
		logic [2:0] bitCnt;
		logic [7:0] shift;
		logic [7:0] rxByte;
		logic tog;
		logic [7:0] txHold;
	} slave_s;

endpackage : spi_fifo_pkg

// >>> verification/spi_fifo_controller_asserts.sv
// Concurrent checks on the serial controller's register and master link ports.
// Assumes one-cycle register strobes; bound to every controller instance.
`timescale 1ns/1ps
`default_nettype none
`include "spi_fifo_controller_defines.svh"
module spi_fifo_controller_asserts (
	input wire logic clk, // system clock
	input wire logic sys_rst, // reset
	input wire logic [31:0] regAddr, // address
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	input wire logic [15:0] regWdata, // write data
	input wire logic [15:0] regRdata, // read data
	input wire logic sclkOut, // master clock
	input wire logic csOut_n, // master select
	input wire logic mosiOut, // master data
	input wire logic txIrq, // transmit interrupt
	input wire logic rxIrq // receive interrupt
);
	logic [15:0] ctrl_r;
	logic [7:0] baud_r;
	logic [12:0] lowCnt_r;
	logic [12:0] byteLen;
	// Shadows let the checks follow whatever mode software last programmed.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_r <= 16'h0000;
			baud_r <= 8'h00;
			lowCnt_r <= 13'h0000;
		end
		else
		begin
			if (regWr && regAddr == `SPI_ADDR_CONTROL)
				ctrl_r <= regWdata;
			if (regWr && regAddr == `SPI_ADDR_BAUD)
				baud_r <= regWdata[7:0];
			lowCnt_r <= csOut_n ? 13'h0000 : lowCnt_r + 13'h0001;
		end
	end
	assign byteLen = ({5'h00, baud_r} + 13'h0001) << 4;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	a_tx_reads_zero: assert property (regRd && regAddr == `SPI_ADDR_TRANSMIT |=> regRdata == 16'h0000)
		else $error("transmit read not zero");
	a_hole_reads_zero: assert property (regRd && regAddr == 32'hffff0a14 |=> regRdata == 16'h0000)
		else $error("unmapped read not zero");
	a_flush_irq_quiet: assert property (ctrl_r[12] && $past(ctrl_r[12]) |-> !txIrq && !rxIrq)
		else $error("interrupt while flushing");
	a_tx_irq_source: assert property (!ctrl_r[6] && !$past(ctrl_r[6]) |-> !txIrq)
		else $error("transmit interrupt in read mode");
	a_rx_irq_source: assert property (ctrl_r[6] && $past(ctrl_r[6]) |-> !rxIrq)
		else $error("receive interrupt in write mode");
	a_byte_length: assert property ($rose(csOut_n) && !ctrl_r[11] |-> lowCnt_r >= byteLen && lowCnt_r <= byteLen + 13'h0002)
		else $error("frame length wrong");
	a_stall_gap: assert property ($rose(csOut_n) && !ctrl_r[11] |-> csOut_n [*2])
		else $error("stall too short");
	a_clock_idle: assert property (csOut_n && $past(csOut_n) && $stable(ctrl_r[3]) |-> sclkOut == ctrl_r[3])
		else $error("clock idle level wrong");
	a_data_on_idle: assert property (!ctrl_r[2] && !csOut_n && $changed(mosiOut) |-> sclkOut == ctrl_r[3])
		else $error("data moved off idle edge");
endmodule : spi_fifo_controller_asserts
bind spi_fifo_controller spi_fifo_controller_asserts chk (.clk, .sys_rst, .regAddr, .regWr, .regRd, .regWdata,
	.regRdata, .sclkOut, .csOut_n, .mosiOut, .txIrq, .rxIrq);
`default_nettype wire

// >>> verification/spi_peer_model.sv
// Behavioural serial slave for the master role, clock polarity and phase clear.
// Assumes the bench reads the last whole byte; data is inverted while deselected.
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
	input wire logic sclk, // serial clock
	input wire logic cs_n, // select, active low
	input wire logic mosi, // data in
	input wire logic [7:0] reply, // byte sent back
	output logic miso, // data out
	output logic [7:0] got // last byte received
);
	logic [7:0] outSh;
	logic [7:0] inSh;
	logic [2:0] cnt;
	initial
	begin
		miso = 1'b0;
		got = 8'h00;
		cnt = 3'h0;
	end
	always @(negedge cs_n)
	begin
		outSh = reply;
		cnt = 3'h0;
		miso = reply[7];
	end
	always @(posedge sclk)
	begin
		if (!cs_n)
		begin
			inSh = {inSh[6:0], mosi};
			cnt = cnt + 3'h1;
			if (cnt == 3'h0)
				got = inSh;
		end
	end
	always @(negedge sclk)
	begin
		if (!cs_n)
		begin
			outSh = {outSh[6:0], outSh[7]};
			miso = outSh[7];
		end
	end
	always @(posedge cs_n)
		miso = ~miso;
endmodule : spi_peer_model
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench: register tasks, master frames to a peer, one slave frame.
// Assumes reads answer one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
`include "spi_fifo_controller_defines.svh"
module testbench;
	logic clk, sys_rst, regWr, regRd, sclkIn, csIn_n, mosiIn, misoOut, misoIn, sclkOut, csOut_n, mosiOut, txIrq, rxIrq;
	logic [31:0] regAddr;
	logic [15:0] regWdata, regRdata;
	logic [7:0] peerGot, sm, sb;
	int err_total, comparisons, m, k, i;
	spi_fifo_controller DUT (.clk, .sys_rst, .regAddr, .regWr, .regRd, .regWdata, .regRdata, .sclkIn, .csIn_n,
		.mosiIn, .misoOut, .misoIn, .sclkOut, .csOut_n, .mosiOut, .txIrq, .rxIrq);
	spi_peer_model peer (.sclk(sclkOut), .cs_n(csOut_n), .mosi(mosiOut), .reply(8'h3c), .miso(misoIn), .got(peerGot));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic summarize;
	begin
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask : summarize
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
	begin
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
	begin
		regAddr = a;
		regWdata = d;
		regWr = 1'b1;
		@(posedge clk);
		#1 regWr = 1'b0;
		@(posedge clk);
		#1;
	end
	endtask : wr
	task automatic rc(input logic [31:0] a, input logic [15:0] mask, input logic [15:0] exp);
	begin
		regAddr = a;
		regRd = 1'b1;
		@(posedge clk);
		#1 regRd = 1'b0;
		@(posedge clk);
		#1 chk(regRdata & mask, exp);
	end
	endtask : rc
	// Waits for one whole master frame, then lets the interrupt flags settle.
	task automatic waitCs;
	int n;
	begin
		for (n = 0; csOut_n !== 1'b0 && n < 3000; n++)
			@(negedge clk);
		for (n = n; csOut_n !== 1'b1 && n < 3000; n++)
			@(negedge clk);
		if (n == 3000)
		begin
			err_total++;
			$display("mismatch at %0t: frame hung", $time);
		end
		repeat (3) @(posedge clk);
		#1;
	end
	endtask : waitCs
	initial
	begin
		#200000;
		err_total++;
		$display("mismatch at %0t: watchdog", $time);
		summarize();
	end
	initial
	begin
		sys_rst = 1'b1;
		regAddr = 32'h00000000;
		regWr = 1'b0;
		regRd = 1'b0;
		regWdata = 16'h0000;
		sclkIn = 1'b1;
		csIn_n = 1'b1;
		mosiIn = 1'b0;
		repeat (16) @(posedge clk);
		#1 sys_rst = 1'b0;
		rc(`SPI_ADDR_STATUS, 16'hffff, 16'h0000);
		rc(`SPI_ADDR_RECEIVE, 16'hffff, 16'h0000);
		rc(32'hffff0a14, 16'hffff, 16'h0000);
		rc(`SPI_ADDR_TRANSMIT, 16'hffff, 16'h0000);
		wr(`SPI_ADDR_BAUD, 16'h0003);
		rc(`SPI_ADDR_BAUD, 16'hffff, 16'h0003);
		// Each mode gets mode+1 bytes, so only the last frame may raise the flag.
		for (m = 0; m < 4; m++)
		begin
			wr(`SPI_ADDR_CONTROL, {m[1:0], 14'h0043});
			for (k = 0; k <= m; k++)
				wr(`SPI_ADDR_TRANSMIT, 16'h00a0 + 16'(k));
			for (k = 0; k <= m; k++)
			begin
				waitCs();
				chk({8'h00, peerGot}, 16'h00a0 + 16'(k));
				chk({15'h0000, txIrq}, {15'h0000, k == m});
			end
		end
		wr(`SPI_ADDR_CONTROL, 16'hc003);
		chk({15'h0000, rxIrq}, 16'h0001);
		rc(`SPI_ADDR_STATUS, 16'hffbf, 16'h00a0);
		wr(`SPI_ADDR_CONTROL, 16'h3003);
		rc(`SPI_ADDR_STATUS, 16'h003f, 16'h0000);
		wr(`SPI_ADDR_TRANSMIT, 16'h0055);
		rc(`SPI_ADDR_STATUS, 16'h0007, 16'h0000);
		rc(`SPI_ADDR_RECEIVE, 16'hff00, 16'h0000);
		waitCs();
		chk({8'h00, peerGot}, 16'h00a3);
		wr(`SPI_ADDR_CONTROL, 16'h3083);
		rc(`SPI_ADDR_RECEIVE, 16'hff00, 16'h0000);
		waitCs();
		chk({8'h00, peerGot}, 16'h0000);
		wr(`SPI_ADDR_CONTROL, 16'h0843);
		for (k = 0; k < 3; k++)
			wr(`SPI_ADDR_TRANSMIT, 16'h00b0 + 16'(k));
		waitCs();
		chk({8'h00, peerGot}, 16'h00b2);
		rc(`SPI_ADDR_RECEIVE, 16'hffff, 16'h003c);
		wr(`SPI_ADDR_CONTROL, 16'h1443);
		wr(`SPI_ADDR_CONTROL, 16'h0443);
		wr(`SPI_ADDR_TRANSMIT, 16'h0096);
		waitCs();
		rc(`SPI_ADDR_RECEIVE, 16'hffff, 16'h0096);
		// Clock idling high with data driven on the leading edge, checked through the loopback path.
		wr(`SPI_ADDR_CONTROL, 16'h044f);
		wr(`SPI_ADDR_TRANSMIT, 16'h0069);
		waitCs();
		rc(`SPI_ADDR_RECEIVE, 16'hffff, 16'h0069);
		wr(`SPI_ADDR_CONTROL, 16'h0000);
		wr(`SPI_ADDR_TRANSMIT, 16'h00c3);
		wr(`SPI_ADDR_CONTROL, 16'h0001);
		repeat (8) @(posedge clk);
		sb = 8'h5e;
		#1 csIn_n = 1'b0;
		for (i = 7; i >= 0; i--)
		begin
			#15 sclkIn = 1'b0;
			mosiIn = sb[i];
			#15 sm[i] = misoOut;
			sclkIn = 1'b1;
		end
		#15 csIn_n = 1'b1;
		mosiIn = ~mosiIn;
		repeat (8) @(posedge clk);
		#1 chk({8'h00, sm}, 16'h00c3);
		rc(`SPI_ADDR_RECEIVE, 16'hffff, 16'h005e);
		summarize();
	end
endmodule : testbench
`default_nettype wire
